// ==== hdl/pss_pkg.sv ====
// pss_pkg: register map, field layout, widths and states of the partial-sleep power sequencer
// assumes a plain one-cycle register port on ref_clk (the peripheral bus clock)
package pss_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int NUM_WAKE = 8;

    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_PUP_SEQ   = 8'h04;
    localparam logic [7:0] OFS_PDN_SEQ   = 8'h08;
    localparam logic [7:0] OFS_WAKE_EN   = 8'h0C;
    localparam logic [7:0] OFS_WAKE_FLAG = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;

    // control register fields
    localparam int CTRL_PSLP_EN  = 0;
    localparam int CTRL_L2_GATE  = 1;
    localparam int CTRL_IT_GATE  = 2;
    localparam int CTRL_DT_GATE  = 3;
    localparam int CTRL_LPCLK_ON = 4;
    localparam int CTRL_W        = 5;

    // sequence register fields: low half first delay, high half second delay
    localparam int SEQ_LO = 0;
    localparam int SEQ_HI = 16;

    // status register fields
    localparam int ST_PDN_FLAG = 0;
    localparam int ST_HP_ON    = 1;
    localparam int ST_ISO      = 2;
    localparam int ST_PARTIAL_SLEEP_MODE   = 3;

    // interrupt events
    localparam int EV_DOWN_DONE = 0;
    localparam int EV_UP_DONE   = 1;
    localparam int EV_WAKE      = 2;
    localparam int EV_W         = 3;

    localparam logic [CNT_W-1:0] SEQ_RESET_VAL = 16'h0001;

    typedef enum logic [2:0] {
        PSS_ON, PSS_WAIT_ISO, PSS_WAIT_OFF, PSS_OFF, PSS_WAIT_SW, PSS_WAIT_UNISO
    } pss_state_type;
endpackage : pss_pkg

// ==== hdl/pss_delay_counter.sv ====
// pss_delay_counter: loads a count and pulses done after that many clocks
// assumes load is a one-cycle pulse and count is nonzero
module pss_delay_counter
    import pss_pkg::*;
#(
    parameter int WIDTH = CNT_W
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic             run_reg;
    logic             run_next;
    logic             done_next;

    always_comb
    begin
        cnt_next  = cnt_reg;
        run_next  = run_reg;
        done_next = 1'b0;
        if (load)
        begin
            cnt_next = count;
            run_next = 1'b1;
        end
        else if (run_reg)
        begin
            // done lands exactly count clocks after load
            if (cnt_reg <= WIDTH'(1))
            begin
                run_next  = 1'b0;
                done_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            done    <= done_next;
        end
    end
endmodule : pss_delay_counter

// ==== hdl/pss_sync2.sv ====
// pss_sync2: two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous levels
module pss_sync2 #(
    parameter int WIDTH = 1
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            dout     <= '0;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : pss_sync2

// ==== hdl/pss_sequencer.sv ====
// pss_sequencer: high-performance domain power sequencer with partial-sleep control
// assumes ref_clk is the peripheral bus clock; low_power_domain interrupts and the
// low-power request are asynchronous pins and are synchronised here
// Functional notes
// - wait switch count, then supply on
// - wait switch-to-isolation, then release isolation
// - wait isolation count, then isolate
// - wait isolation-to-switch, then supply off
// - partial sleep: domain off, system clocks stopped
// - enabled low-power sources wake the system
// - wake flags read-only, follow source interrupt
// - control bit picks partial sleep or stop; here a clear bit ignores the request and there is no stop mode
// - cache and tight memories gated separately
// - powered-down flag set on real power-down
//
// Local design decisions: the address map and the address-and-strobe port.
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int NWAKE = NUM_WAKE
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regRdata,
    input  wire logic              lowPowerReq,
    input  wire logic [NWAKE-1:0]  lpIrqIn,
    output logic                   hpSupplyOn,
    output logic                   hpIsolate,
    output logic                   sysClockOn,
    output logic                   lpPeriphClockOn,
    output logic                   l2CacheGate,
    output logic                   instrTightMemGate,
    output logic                   dataTightMemGate,
    output logic                   irqOut
);
    logic [NWAKE-1:0]  lpIrqSync;
    logic              lpReqSync;
    logic [CTRL_W-1:0] ctrl_reg,     ctrl_next;
    logic [DATA_W-1:0] pupSeq_reg,   pupSeq_next;
    logic [DATA_W-1:0] pdnSeq_reg,   pdnSeq_next;
    logic [NWAKE-1:0]  wakeEn_reg,   wakeEn_next;
    logic [NWAKE-1:0]  wakeFlag_reg, wakeFlag_next;
    logic              pdnFlag_reg,  pdnFlag_next;
    logic [EV_W-1:0]   irqStat_reg,  irqStat_next;
    logic [EV_W-1:0]   irqEn_reg,    irqEn_next;
    logic [DATA_W-1:0] rdata_next;
    pss_state_type     state_reg,    state_next;
    logic              supply_next,  iso_next, sysClk_next, lpClk_next;
    logic              l2_next,      it_next,  dt_next,     irq_next;
    logic              cntLoad;
    logic [CNT_W-1:0]  cntValue;
    logic              cntDone;
    logic [EV_W-1:0]   events;
    logic              wakeHit;
    logic              pslpActive;

    pss_sync2 #(.WIDTH(NWAKE + 1)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     ({lowPowerReq, lpIrqIn}),
        .dout    ({lpReqSync, lpIrqSync})
    );

    pss_delay_counter #(.WIDTH(CNT_W)) u_delay (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (cntLoad),
        .count   (cntValue),
        .done    (cntDone)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic [CNT_W-1:0] field(input logic [DATA_W-1:0] r, input int lsb);
        field = r[lsb +: CNT_W];
    endfunction : field

    // a wake source counts only while enabled and while in partial sleep
    // enabled wake sources
    assign wakeHit    = |(lpIrqSync & wakeEn_reg);
    assign pslpActive = (state_reg == PSS_OFF) && ctrl_reg[CTRL_PSLP_EN];

    // sequencing state machine
    always_comb
    begin
        state_next = state_reg;
        cntLoad    = 1'b0;
        cntValue   = '0;
        events     = '0;
        unique case (state_reg)
            PSS_ON:
            begin
                if (lpReqSync && ctrl_reg[CTRL_PSLP_EN])
                begin
                    cntLoad    = 1'b1;
                    cntValue   = field(pdnSeq_reg, SEQ_LO);
                    state_next = PSS_WAIT_ISO;
                end
            end
            PSS_WAIT_ISO:
            begin
                if (cntDone)
                begin
                    cntLoad    = 1'b1;
                    cntValue   = field(pdnSeq_reg, SEQ_HI);
                    state_next = PSS_WAIT_OFF;
                end
            end
            PSS_WAIT_OFF:
            begin
                if (cntDone)
                begin
                    events[EV_DOWN_DONE] = 1'b1;
                    state_next           = PSS_OFF;
                end
            end
            PSS_OFF:
            begin
                // a wake interrupt or a dropped request starts power-up
                if (wakeHit || !lpReqSync)
                begin
                    cntLoad          = 1'b1;
                    cntValue         = field(pupSeq_reg, SEQ_LO);
                    events[EV_WAKE]  = wakeHit;
                    state_next       = PSS_WAIT_SW;
                end
            end
            PSS_WAIT_SW:
            begin
                if (cntDone)
                begin
                    cntLoad    = 1'b1;
                    cntValue   = field(pupSeq_reg, SEQ_HI);
                    state_next = PSS_WAIT_UNISO;
                end
            end
            PSS_WAIT_UNISO:
            begin
                if (cntDone)
                begin
                    events[EV_UP_DONE] = 1'b1;
                    state_next         = PSS_ON;
                end
            end
            // two spare codes of the 3-bit state fall back to powered
            default:
            begin
                state_next = PSS_ON;
            end
        endcase
    end

    // outputs derived from the next state so every pin is a flop
    always_comb
    begin
        supply_next = 1'b1;
        iso_next    = 1'b0;
        unique case (state_next)
            PSS_ON:
            begin
                supply_next = 1'b1;
                iso_next    = 1'b0;
            end
            // isolation held off during the isolation count
            PSS_WAIT_ISO:
            begin
                supply_next = 1'b1;
                iso_next    = 1'b0;
            end
            // isolation asserted once that count ends
            PSS_WAIT_OFF:
            begin
                supply_next = 1'b1;
                iso_next    = 1'b1;
            end
            PSS_OFF:
            begin
                supply_next = 1'b0;
                iso_next    = 1'b1;
            end
            PSS_WAIT_SW:
            begin
                supply_next = 1'b0;
                iso_next    = 1'b1;
            end
            PSS_WAIT_UNISO:
            begin
                supply_next = 1'b1;
                iso_next    = 1'b1;
            end
            default:
            begin
                supply_next = 1'b1;
                iso_next    = 1'b0;
            end
        endcase
        // isolation drops only on return to PSS_ON
        // system clocks stop with the supply, low-power clocks optional
        sysClk_next = supply_next;
        lpClk_next  = sysClk_next || ctrl_reg[CTRL_LPCLK_ON];
        // memory power gates, only while the domain is down
        l2_next     = ctrl_reg[CTRL_L2_GATE] && !supply_next;
        it_next     = ctrl_reg[CTRL_IT_GATE] && !supply_next;
        dt_next     = ctrl_reg[CTRL_DT_GATE] && !supply_next;
    end

    // register file
    always_comb
    begin
        ctrl_next     = ctrl_reg;
        pupSeq_next   = pupSeq_reg;
        pdnSeq_next   = pdnSeq_reg;
        wakeEn_next   = wakeEn_reg;
        irqEn_next    = irqEn_reg;
        wakeFlag_next = wakeFlag_reg;
        pdnFlag_next  = pdnFlag_reg;
        irqStat_next  = irqStat_reg;
        rdata_next    = '0;
        if (regWrite)
        begin
            if (hit(regAddr, OFS_CTRL))
                ctrl_next = regWdata[CTRL_W-1:0];
            // zero delays are a software fault, not guarded here
            if (hit(regAddr, OFS_PUP_SEQ))
                pupSeq_next = regWdata;
            if (hit(regAddr, OFS_PDN_SEQ))
                pdnSeq_next = regWdata;
            if (hit(regAddr, OFS_WAKE_EN))
                wakeEn_next = regWdata[NWAKE-1:0];
            if (hit(regAddr, OFS_IRQ_EN))
                irqEn_next = regWdata[EV_W-1:0];
            if (hit(regAddr, OFS_STATUS) && regWdata[ST_PDN_FLAG])
                pdnFlag_next = 1'b0;
            if (hit(regAddr, OFS_IRQ_CLR))
                irqStat_next = irqStat_reg & ~regWdata[EV_W-1:0];
        end
        wakeFlag_next = wakeFlag_next & lpIrqSync;
        if (pslpActive)
            wakeFlag_next = wakeFlag_next | (lpIrqSync & wakeEn_reg);
        if (events[EV_DOWN_DONE])
            pdnFlag_next = 1'b1;
        irqStat_next = irqStat_next | events;
        if (regRead)
        begin
            unique case (1'b1)
                hit(regAddr, OFS_CTRL):      rdata_next = DATA_W'(ctrl_reg);
                hit(regAddr, OFS_PUP_SEQ):   rdata_next = pupSeq_reg;
                hit(regAddr, OFS_PDN_SEQ):   rdata_next = pdnSeq_reg;
                hit(regAddr, OFS_WAKE_EN):   rdata_next = DATA_W'(wakeEn_reg);
                hit(regAddr, OFS_WAKE_FLAG): rdata_next = DATA_W'(wakeFlag_reg);
                hit(regAddr, OFS_STATUS):
                begin
                    rdata_next[ST_PDN_FLAG] = pdnFlag_reg;
                    rdata_next[ST_HP_ON]    = hpSupplyOn;
                    rdata_next[ST_ISO]      = hpIsolate;
                    rdata_next[ST_PARTIAL_SLEEP_MODE]   = pslpActive;
                end
                hit(regAddr, OFS_IRQ_STAT):  rdata_next = DATA_W'(irqStat_reg);
                hit(regAddr, OFS_IRQ_EN):    rdata_next = DATA_W'(irqEn_reg);
                default:                     rdata_next = '0;
            endcase
        end
        irq_next = |(irqStat_next & irqEn_next);
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= PSS_ON;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // pin flops; reset keeps the domain powered and connected
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hpSupplyOn        <= 1'b1;
            hpIsolate         <= 1'b0;
            sysClockOn        <= 1'b1;
            lpPeriphClockOn   <= 1'b1;
            l2CacheGate       <= 1'b0;
            instrTightMemGate <= 1'b0;
            dataTightMemGate  <= 1'b0;
        end
        else
        begin
            hpSupplyOn        <= supply_next;
            hpIsolate         <= iso_next;
            sysClockOn        <= sysClk_next;
            lpPeriphClockOn   <= lpClk_next;
            l2CacheGate       <= l2_next;
            instrTightMemGate <= it_next;
            dataTightMemGate  <= dt_next;
        end
    end

    // register file, read data and interrupt flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg          <= '0;
            pupSeq_reg        <= {SEQ_RESET_VAL, SEQ_RESET_VAL};
            pdnSeq_reg        <= {SEQ_RESET_VAL, SEQ_RESET_VAL};
            wakeEn_reg        <= '0;
            wakeFlag_reg      <= '0;
            pdnFlag_reg       <= 1'b0;
            irqStat_reg       <= '0;
            irqEn_reg         <= '0;
            regRdata          <= '0;
            irqOut            <= 1'b0;
        end
        else
        begin
            ctrl_reg          <= ctrl_next;
            pupSeq_reg        <= pupSeq_next;
            pdnSeq_reg        <= pdnSeq_next;
            wakeEn_reg        <= wakeEn_next;
            wakeFlag_reg      <= wakeFlag_next;
            pdnFlag_reg       <= pdnFlag_next;
            irqStat_reg       <= irqStat_next;
            irqEn_reg         <= irqEn_next;
            regRdata          <= rdata_next;
            irqOut            <= irq_next;
        end
    end
endmodule : pss_sequencer

// ==== bench/pss_sequencer_props.sv ====
// pss_sequencer_props: pin timing checks for pss_sequencer
// assumes the package register map; delay settings are snooped from writes
module pss_sequencer_props
    import pss_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              lowPowerReq,
    input wire logic              hpSupplyOn,
    input wire logic              hpIsolate,
    input wire logic              sysClockOn,
    input wire logic              lpPeriphClockOn,
    input wire logic              l2CacheGate,
    input wire logic              instrTightMemGate,
    input wire logic              dataTightMemGate
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [16:0] downMin_reg;
    logic [16:0] upMin_reg;
    logic [16:0] isoCnt_reg;
    logic [16:0] onCnt_reg;
    logic [16:0] isoMin_reg;
    logic [16:0] reqCnt_reg;
    // minimum only: stage overhead of the counters is left open
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            downMin_reg <= 17'h00001;
            isoMin_reg  <= 17'h00001;
            reqCnt_reg  <= 17'h00000;
            upMin_reg   <= 17'h00001;
            isoCnt_reg  <= 17'h00000;
            onCnt_reg   <= 17'h00000;
        end
        else
        begin
            if (regWrite && regAddr == OFS_PDN_SEQ)
            begin
                downMin_reg <= {1'b0, regWdata[31:16]};
                isoMin_reg  <= {1'b0, regWdata[15:0]};
            end
            reqCnt_reg <= lowPowerReq ? reqCnt_reg + 17'h00001 : 17'h00000;
            if (regWrite && regAddr == OFS_PUP_SEQ)
                upMin_reg <= {1'b0, regWdata[31:16]};
            isoCnt_reg <= hpIsolate ? isoCnt_reg + 17'h00001 : 17'h00000;
            onCnt_reg  <= hpSupplyOn ? onCnt_reg + 17'h00001 : 17'h00000;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_down_wait;
        $fell(hpSupplyOn) |-> isoCnt_reg >= downMin_reg;
    endproperty
    a_down_wait: assert property (p_down_wait)
        else $error("supply cut before isolation-to-switch delay");
    property p_iso_wait;
        $rose(hpIsolate) |-> reqCnt_reg >= isoMin_reg;
    endproperty
    a_iso_wait: assert property (p_iso_wait)
        else $error("isolation before the isolation delay");
    property p_up_wait;
        $fell(hpIsolate) |-> onCnt_reg >= upMin_reg;
    endproperty
    a_up_wait: assert property (p_up_wait)
        else $error("isolation released too early");
    property p_off_isolated;
        !hpSupplyOn |-> hpIsolate;
    endproperty
    a_off_isolated: assert property (p_off_isolated)
        else $error("unpowered domain not isolated");
    property p_on_isolated;
        $rose(hpSupplyOn) |-> hpIsolate;
    endproperty
    a_on_isolated: assert property (p_on_isolated)
        else $error("supply returned without isolation");
    property p_iso_hold;
        $rose(hpIsolate) |-> hpSupplyOn [*2];
    endproperty
    a_iso_hold: assert property (p_iso_hold)
        else $error("supply dropped with isolation");
    property p_rdata_idle;
        !$past(regRead) |-> regRdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_gates_on;
        hpSupplyOn && $past(hpSupplyOn) |-> !(l2CacheGate || instrTightMemGate || dataTightMemGate);
    endproperty
    a_gates_on: assert property (p_gates_on)
        else $error("memory gated while powered");
    property p_clk_stop;
        $fell(hpSupplyOn) |-> ##1 !sysClockOn && !hpSupplyOn;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("system clock runs while off");
    property p_lp_clk;
        sysClockOn && $past(sysClockOn) |-> lpPeriphClockOn;
    endproperty
    a_lp_clk: assert property (p_lp_clk)
        else $error("peripheral clock stopped with system clock");
    c_down: cover property ($fell(hpSupplyOn));
    c_up: cover property ($fell(hpIsolate));
    c_gate: cover property ($rose(l2CacheGate));
endmodule : pss_sequencer_props

bind pss_sequencer pss_sequencer_props u_props (
    .ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .lowPowerReq,
    .hpSupplyOn, .hpIsolate, .sysClockOn, .lpPeriphClockOn,
    .l2CacheGate, .instrTightMemGate, .dataTightMemGate
);

// ==== bench/pss_far_side.sv ====
// pss_far_side: switched domain cells and low-power peripherals
// assumes irqHold is the peripheral interrupt status set by the bench
module pss_far_side
    import pss_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                hpSupplyOn,
    input  wire logic                hpIsolate,
    input  wire logic [NUM_WAKE-1:0] irqHold,
    output logic      [NUM_WAKE-1:0] lpIrqIn,
    output logic                     domainAlive
);
    timeunit 1ns;
    timeprecision 100ps;
    // interrupts are asynchronous to the bus clock
    assign #3 lpIrqIn = irqHold;
    always_ff @(posedge ref_clk)
        domainAlive <= hpSupplyOn && !hpIsolate;
endmodule : pss_far_side

// ==== bench/pss_sequencer_bench.sv ====
// pss_sequencer_bench: register-level tests of the power sequencer
// assumes the package map; bus clock 100 MHz
module pss_sequencer_bench
    import pss_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [ADDR_W-1:0]   regAddr = '0;
    logic [DATA_W-1:0]   regWdata = '0;
    logic                regWrite = 1'b0;
    logic                regRead = 1'b0;
    logic [DATA_W-1:0]   regRdata;
    logic                lowPowerReq = 1'b0;
    logic [NUM_WAKE-1:0] irqHold = '0;
    logic [NUM_WAKE-1:0] lpIrqIn;
    logic                hpSupplyOn, hpIsolate, sysClockOn, lpPeriphClockOn;
    logic                l2CacheGate, instrTightMemGate, dataTightMemGate, irqOut, domainAlive;
    int                  failures = 0;
    int                  checked = 0;
    int                  n, i1, d1, s1, u1, i2, d2, s2, u2;
    pss_sequencer u_dut (.ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .lowPowerReq, .lpIrqIn, .hpSupplyOn, .hpIsolate, .sysClockOn, .lpPeriphClockOn,
        .l2CacheGate, .instrTightMemGate, .dataTightMemGate, .irqOut);
    pss_far_side u_far (.ref_clk, .hpSupplyOn, .hpIsolate, .irqHold, .lpIrqIn, .domainAlive);
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask : rdc
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    // bounded wait; k 0 watches supply, 1 isolation
    task automatic waitFor(input int k, input logic v, output int cnt);
        cnt = 0;
        while ((k == 0 ? hpSupplyOn : hpIsolate) !== v && cnt < 400)
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
        chk(cnt < 400, 1);
    endtask : waitFor
    task automatic cycle(input logic [31:0] ctrl, pdn, pup, output int i, d, s, u);
        wr(OFS_CTRL, ctrl);
        wr(OFS_PDN_SEQ, pdn);
        wr(OFS_PUP_SEQ, pup);
        lowPowerReq <= 1'b1;
        waitFor(1, 1'b1, i);
        waitFor(0, 1'b0, d);
        settle();
        chk({sysClockOn, domainAlive}, 2'b00);
        chk({lpPeriphClockOn, dataTightMemGate, instrTightMemGate, l2CacheGate}, ctrl[4:1]);
        chk(irqOut, 1'b1);
        rdc(OFS_STATUS, 32'h0000000D);
        @(posedge ref_clk);
        lowPowerReq <= 1'b0;
        waitFor(0, 1'b1, s);
        waitFor(1, 1'b0, u);
        settle();
        chk({sysClockOn, domainAlive, l2CacheGate, instrTightMemGate, dataTightMemGate}, 5'h18);
        rdc(OFS_IRQ_STAT, 32'h00000003);
        wr(OFS_IRQ_CLR, 32'h00000007);
        wr(OFS_STATUS, 32'h00000000);
        rdc(OFS_STATUS, 32'h00000003);
        wr(OFS_STATUS, 32'h00000001);
        rdc(OFS_STATUS, 32'h00000002);
        chk(irqOut, 1'b0);
    endtask : cycle
    initial
    begin
        #50us;
        failures++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk({hpSupplyOn, hpIsolate, sysClockOn, lpPeriphClockOn, irqOut}, 5'h16);
        rdc(OFS_PDN_SEQ, 32'h00010001);
        rdc(OFS_STATUS, 32'h00000002);
        rdc(8'h24, 32'h00000000);
        rdc(OFS_IRQ_CLR, 32'h00000000);
        wr(OFS_IRQ_EN, 32'h00000007);
        wr(OFS_WAKE_EN, 32'h00000005);
        wr(OFS_CTRL, 32'h0000000E);
        lowPowerReq <= 1'b1;
        repeat (30) @(posedge ref_clk);
        #1;
        chk(hpSupplyOn, 1'b1);
        @(posedge ref_clk);
        lowPowerReq <= 1'b0;
        cycle(32'h0F, 32'h00030002, 32'h00040002, i1, d1, s1, u1);
        cycle(32'h13, 32'h00070005, 32'h00090006, i2, d2, s2, u2);
        chk(i2 - i1, 3);
        chk(d2 - d1, 4);
        chk(s2 - s1, 4);
        chk(u2 - u1, 5);
        @(posedge ref_clk);
        lowPowerReq <= 1'b1;
        waitFor(0, 1'b0, n);
        @(posedge ref_clk);
        irqHold <= 8'h02;
        repeat (20) @(posedge ref_clk);
        #1;
        chk(hpSupplyOn, 1'b0);
        @(posedge ref_clk);
        irqHold <= 8'h06;
        waitFor(0, 1'b1, n);
        @(posedge ref_clk);
        lowPowerReq <= 1'b0;
        waitFor(1, 1'b0, n);
        rdc(OFS_WAKE_FLAG, 32'h00000004);
        wr(OFS_WAKE_FLAG, 32'h00000000);
        rdc(OFS_WAKE_FLAG, 32'h00000004);
        wr(OFS_IRQ_CLR, 32'h00000003);
        wr(OFS_IRQ_EN, 32'h00000000);
        settle();
        chk(irqOut, 1'b0);
        wr(OFS_IRQ_EN, 32'h00000004);
        settle();
        chk(irqOut, 1'b1);
        @(posedge ref_clk);
        irqHold <= 8'h00;
        wr(OFS_IRQ_CLR, 32'h00000004);
        settle();
        chk(irqOut, 1'b0);
        rdc(OFS_WAKE_FLAG, 32'h00000000);
        wrap_up();
    end
endmodule : pss_sequencer_bench
